// ===== hdl/ife_pkg.sv
package ife_pkg;
   // bus and register widths
   localparam int DATA_W  = 8;
   localparam int NFLAG   = 7;
   localparam int SEL_W   = 4;
   localparam int SUM_BIT = 7;  // summary bit of the flag register, set/clear select of the enable write

   // register select codes
   localparam logic [SEL_W-1:0] REG_PORT_B    = 4'h0;
   localparam logic [SEL_W-1:0] REG_PORT_A    = 4'h1;
   localparam logic [SEL_W-1:0] REG_FLAGS     = 4'hd;
   localparam logic [SEL_W-1:0] REG_ENABLE    = 4'he;
   localparam logic [SEL_W-1:0] REG_PORT_A_NH = 4'hf;

   // flag bit positions
   localparam int FLG_PORT_A_LINE_2 = 0;
   localparam int FLG_PORT_A_LINE_1 = 1;
   localparam int FLG_SR            = 2;
   localparam int FLG_PORT_B_LINE_2 = 3;
   localparam int FLG_PORT_B_LINE_1 = 4;
   localparam int FLG_T2            = 5;
   localparam int FLG_T1            = 6;

   // reset values
   localparam logic [NFLAG-1:0]  FLAGS_RST = 7'h00;
   localparam logic [NFLAG-1:0]  EN_RST    = 7'h00;
   localparam logic [DATA_W-1:0] DOUT_RST  = 8'h00;
endpackage

// ===== hdl/ife_enable_reg.sv
// enable register with bit-selective set or clear write
module ife_enable_reg (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rstn,
   // write strobe and data
   input  wire logic                           wr,
   input  wire logic [ife_pkg::DATA_W-1:0]     wdata,
   // enable state
   output logic      [ife_pkg::NFLAG-1:0]      en
);
   import ife_pkg::*;

   logic [NFLAG-1:0] next_en;

   // data bit 7 picks set or clear, ones select the bits touched
   always_comb begin
      next_en = en;
      if (wr) begin
         if (wdata[SUM_BIT]) begin
            next_en = en | wdata[NFLAG-1:0];
         end else begin
            next_en = en & ~wdata[NFLAG-1:0];
         end
      end
   end

   // enable storage, all disabled after reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         en <= EN_RST;
      end else begin
         en <= next_en;
      end
   end
endmodule

// ===== hdl/ife_unit.sv
module ife_unit (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rstn,
   // processor register bus
   input  wire logic                           chip_sel,
   input  wire logic                           chip_sel2_n,
   input  wire logic [ife_pkg::SEL_W-1:0]      reg_sel,
   input  wire logic                           read_not_write,
   input  wire logic [ife_pkg::DATA_W-1:0]     data_in,
   output logic      [ife_pkg::DATA_W-1:0]     data_out,
   output logic                                data_oe,
   // interrupt request, open drain
   output logic                                irq_n,
   output logic                                irq_oe,
   // flag sources
   input  wire logic [ife_pkg::NFLAG-1:0]      flag_set,
   input  wire logic [ife_pkg::NFLAG-1:0]      flag_service_clr,
   // control-line configuration
   input  wire logic                           port_a_line_2_independent,
   input  wire logic                           port_b_line_2_independent
);
   import ife_pkg::*;

   function automatic logic hit(input logic [SEL_W-1:0] sel, input logic [SEL_W-1:0] code);
      hit = (sel == code);
   endfunction

   function automatic logic summary(input logic [NFLAG-1:0] f, input logic [NFLAG-1:0] e);
      summary = |(f & e);
   endfunction

   // enable value after this cycle's write, same update as the enable register
   function automatic logic [NFLAG-1:0] en_after(input logic [NFLAG-1:0] e, input logic w,
                                                 input logic [DATA_W-1:0] d);
      en_after = e;
      if (w) begin
         en_after = d[SUM_BIT] ? (e | d[NFLAG-1:0]) : (e & ~d[NFLAG-1:0]);
      end
   endfunction

   logic [NFLAG-1:0]  flags;
   logic [NFLAG-1:0]  en;
   logic [NFLAG-1:0]  next_flags;
   logic [DATA_W-1:0] next_data_out;
   logic              next_data_oe;
   logic              next_irq_n;
   logic              acc;
   logic              wr_flags;
   logic              wr_en;
   logic              rd_flags;
   logic              rd_en;
   logic              port_a_acc;
   logic              port_b_acc;
   logic [NFLAG-1:0]  port_clr;

   // access decode
   assign acc        = chip_sel & ~chip_sel2_n;
   assign wr_flags   = acc & ~read_not_write & hit(reg_sel, REG_FLAGS);
   assign wr_en      = acc & ~read_not_write & hit(reg_sel, REG_ENABLE);
   assign rd_flags   = acc & read_not_write & hit(reg_sel, REG_FLAGS);
   assign rd_en      = acc & read_not_write & hit(reg_sel, REG_ENABLE);
   assign port_a_acc = acc & (hit(reg_sel, REG_PORT_A) | hit(reg_sel, REG_PORT_A_NH));
   assign port_b_acc = acc & hit(reg_sel, REG_PORT_B);

   // port accesses clear line 1 flags, and line 2 flags unless line 2 is independent
   always_comb begin
      port_clr          = '0;
      port_clr[FLG_PORT_A_LINE_1] = port_a_acc;
      port_clr[FLG_PORT_A_LINE_2] = port_a_acc & ~port_a_line_2_independent;
      port_clr[FLG_PORT_B_LINE_1] = port_b_acc;
      port_clr[FLG_PORT_B_LINE_2] = port_b_acc & ~port_b_line_2_independent;
   end

   // enable register
   ife_enable_reg u_enable (
      .clk   (clk),
      .rstn  (rstn),
      .wr    (wr_en),
      .wdata (data_in),
      .en    (en)
   );

   // flag next state, a set event wins over any clear
   always_comb begin
      next_flags = flags;
      if (wr_flags) begin
         next_flags = next_flags & ~data_in[NFLAG-1:0];
      end
      next_flags = next_flags & ~flag_service_clr & ~port_clr;
      next_flags = next_flags | flag_set;
   end

   // request tracks the registered flags and enables
   always_comb begin
      next_irq_n = ~summary(next_flags, en_after(en, wr_en, data_in));
   end

   // read data, driven the cycle after a read access
   always_comb begin
      next_data_out = data_out;
      next_data_oe  = 1'b0;
      if (rd_flags) begin
         next_data_out = {summary(flags, en), flags};
         next_data_oe  = 1'b1;
      end else if (rd_en) begin
         next_data_out = {1'b0, en};
         next_data_oe  = 1'b1;
      end else if (acc & read_not_write) begin
         next_data_out = DOUT_RST;
         next_data_oe  = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags    <= FLAGS_RST;
         irq_n    <= 1'b1;
         irq_oe   <= 1'b0;
         data_out <= DOUT_RST;
         data_oe  <= 1'b0;
      end else begin
         flags    <= next_flags;
         irq_n    <= next_irq_n;
         irq_oe   <= ~next_irq_n;
         data_out <= next_data_out;
         data_oe  <= next_data_oe;
      end
   end

   // checks
   property p_flag_clear;
      @(posedge clk) disable iff (!rstn)
         (wr_flags && flag_set == '0) |=> ((flags & $past(data_in[NFLAG-1:0])) == '0);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("written flag not cleared");

   property p_flag_keep;
      @(posedge clk) disable iff (!rstn)
         (wr_flags && flag_set == '0 && flag_service_clr == '0 && port_clr == '0) |=>
            ((flags & ~$past(data_in[NFLAG-1:0])) == ($past(flags) & ~$past(data_in[NFLAG-1:0])));
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag written zero changed");

   property p_summary_read;
      @(posedge clk) disable iff (!rstn)
         rd_flags |=> (data_oe && data_out[SUM_BIT] == ~$past(irq_n));
   endproperty
   a_summary_read: assert property (p_summary_read) else $error("summary bit differs from request");

   property p_irq_tracks;
      @(posedge clk) disable iff (!rstn)
         (irq_n == ~summary(flags, en)) && (irq_oe == ~irq_n);
   endproperty
   a_irq_tracks: assert property (p_irq_tracks) else $error("request not equal to flag and enable");

   property p_enable_clear;
      @(posedge clk) disable iff (!rstn)
         (wr_en && !data_in[SUM_BIT]) |=> ((en & $past(data_in[NFLAG-1:0])) == '0);
   endproperty
   a_enable_clear: assert property (p_enable_clear) else $error("enable not cleared");

   property p_enable_set;
      @(posedge clk) disable iff (!rstn)
         (wr_en && data_in[SUM_BIT]) |=>
            ((en & ~$past(data_in[NFLAG-1:0])) == ($past(en) & ~$past(data_in[NFLAG-1:0])))
            && ((en & $past(data_in[NFLAG-1:0])) == $past(data_in[NFLAG-1:0]));
   endproperty
   a_enable_set: assert property (p_enable_set) else $error("enable set wrong");

   property p_enable_read;
      @(posedge clk) disable iff (!rstn)
         rd_en |=> (data_oe && data_out == {1'b0, $past(en)});
   endproperty
   a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

   property p_read_strobe;
      @(posedge clk) disable iff (!rstn)
         !(acc && read_not_write) |=> !data_oe;
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("read strobe without read access");

   property p_indep_keep;
      @(posedge clk) disable iff (!rstn)
         (port_a_acc && port_a_line_2_independent && !wr_flags && !flag_service_clr[FLG_PORT_A_LINE_2]) |=>
            (flags[FLG_PORT_A_LINE_2] == $past(flags[FLG_PORT_A_LINE_2]) || $past(flag_set[FLG_PORT_A_LINE_2]));
   endproperty
   a_indep_keep: assert property (p_indep_keep) else $error("independent flag cleared by port access");

   property p_indep_keep_b;
      @(posedge clk) disable iff (!rstn)
         (port_b_acc && port_b_line_2_independent && !wr_flags && !flag_service_clr[FLG_PORT_B_LINE_2]) |=>
            (flags[FLG_PORT_B_LINE_2] == $past(flags[FLG_PORT_B_LINE_2]) || $past(flag_set[FLG_PORT_B_LINE_2]));
   endproperty
   a_indep_keep_b: assert property (p_indep_keep_b) else $error("independent flag cleared by port access");

   property p_sticky;
      @(posedge clk) disable iff (!rstn)
         (!wr_flags && flag_service_clr == '0 && port_clr == '0) |=> ((flags & $past(flags)) == $past(flags));
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

   property p_set_wins;
      @(posedge clk) disable iff (!rstn)
         (flag_set != '0) |=> ((flags & $past(flag_set)) == $past(flag_set)) ##1 (irq_n == ~summary(flags, en));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set event lost");

   // main scenarios
   c_irq_assert:  cover property (@(posedge clk) disable iff (!rstn) $fell(irq_n));
   c_flag_clear:  cover property (@(posedge clk) disable iff (!rstn) wr_flags ##1 $rose(irq_n));
   c_en_disable:  cover property (@(posedge clk) disable iff (!rstn) (wr_en && !data_in[SUM_BIT] && !irq_n) ##1 irq_n);
   c_indep_port:  cover property (@(posedge clk) disable iff (!rstn)
                     port_a_acc && port_a_line_2_independent && flags[FLG_PORT_A_LINE_2]);
   c_poll_req:    cover property (@(posedge clk) disable iff (!rstn) rd_flags && !irq_n);
endmodule

// ===== verification/ife_host_model.sv
// host processor side of the register bus
module ife_host_model (
   // bus clock
   input  wire logic                       clk,
   // register bus toward the device
   output logic                            chip_sel,
   output logic                            chip_sel2_n,
   output logic [ife_pkg::SEL_W-1:0]       reg_sel,
   output logic                            read_not_write,
   output wire logic [ife_pkg::DATA_W-1:0] data_in,
   // read answer
   input  wire logic [ife_pkg::DATA_W-1:0] data_out,
   input  wire logic                       data_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   import ife_pkg::*;
   logic [DATA_W-1:0] wd = 8'h00;
   logic [DATA_W-1:0] rdata;
   logic              roe;
   // idle data bus shows the inverse of the last word
   assign data_in = chip_sel ? wd : ~wd;
   initial begin
      chip_sel = 1'b0;
      chip_sel2_n = 1'b1;
      reg_sel = 4'h0;
      read_not_write = 1'b1;
   end
   // one-cycle access; a flag is cleared by writing a one to it
   task acc(input logic [SEL_W-1:0] s, input logic rw, input logic [DATA_W-1:0] d);
      @(posedge clk);
      chip_sel <= 1'b1;
      chip_sel2_n <= 1'b0;
      reg_sel <= s;
      read_not_write <= rw;
      wd <= d;
      @(posedge clk);
      chip_sel <= 1'b0;
      chip_sel2_n <= 1'b1;
      #1;
      rdata = data_out;
      roe = data_oe;
   endtask
endmodule

// ===== verification/tb_top.sv
// register-level bench of the interrupt flag and enable unit
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ife_pkg::*;
   logic              clk = 1'b0;
   logic              rstn = 1'b0;
   logic              cs, cs2_n, rnw, oe, irq_n, irq_oe;
   logic [SEL_W-1:0]  sel;
   logic [DATA_W-1:0] din, dout;
   logic [NFLAG-1:0]  fset = 7'h00;
   logic [NFLAG-1:0]  fclr = 7'h00;
   logic              ca_ind = 1'b0;
   logic              cb_ind = 1'b0;
   int                bad_count = 0;
   int                comparisons = 0;
   logic [3:0]        psel [4] = '{4'h1, 4'h0, 4'hf, 4'h0};
   logic [1:0]        pind [4] = '{2'b11, 2'b11, 2'b00, 2'b00};
   logic [7:0]        pexp [4] = '{8'h19, 8'h09, 8'h08, 8'h00};
   always #12.5 clk = ~clk;
   ife_unit DUT (.clk(clk), .rstn(rstn), .chip_sel(cs), .chip_sel2_n(cs2_n), .reg_sel(sel),
      .read_not_write(rnw), .data_in(din), .data_out(dout), .data_oe(oe), .irq_n(irq_n),
      .irq_oe(irq_oe), .flag_set(fset), .flag_service_clr(fclr), .port_a_line_2_independent(ca_ind),
      .port_b_line_2_independent(cb_ind));
   ife_host_model host (.clk(clk), .chip_sel(cs), .chip_sel2_n(cs2_n), .reg_sel(sel),
      .read_not_write(rnw), .data_in(din), .data_out(dout), .data_oe(oe));
   // compare and count
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask
   // read a register and compare data and strobe
   task rd(input logic [SEL_W-1:0] s, input logic [7:0] exp);
      host.acc(s, 1'b1, 8'h00);
      chk(host.rdata, exp);
      chk({7'h00, host.roe}, 8'h01);
   endtask
   task wr(input logic [SEL_W-1:0] s, input logic [7:0] d);
      host.acc(s, 1'b0, d);
   endtask
   // request pins as {oe, level}
   task irq(input logic [7:0] exp);
      chk({6'h00, irq_oe, irq_n}, exp);
   endtask
   task pulse(input logic [NFLAG-1:0] s, input logic [NFLAG-1:0] c);
      @(posedge clk);
      fset <= s;
      fclr <= c;
      @(posedge clk);
      fset <= 7'h00;
      fclr <= 7'h00;
      #1;
   endtask
   task summarize;
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // watchdog well past the expected run
   initial begin
      #50000;
      bad_count++;
      summarize;
   end
   initial begin
      repeat (5) @(posedge clk);
      #1;
      irq(8'h01);
      @(posedge clk);
      rstn <= 1'b1;
      rd(REG_FLAGS, 8'h00);
      rd(REG_ENABLE, 8'h00);
      wr(REG_ENABLE, 8'hc1);
      rd(REG_ENABLE, 8'h41);
      wr(REG_ENABLE, 8'h01);
      rd(REG_ENABLE, 8'h40);
      pulse(7'h44, 7'h00);
      irq(8'h02);
      repeat (5) @(posedge clk);
      rd(REG_FLAGS, 8'hc4);
      wr(REG_FLAGS, 8'h80);
      rd(REG_FLAGS, 8'hc4);
      wr(REG_ENABLE, 8'h40);
      rd(REG_FLAGS, 8'h44);
      irq(8'h01);
      wr(REG_ENABLE, 8'hc0);
      wr(REG_FLAGS, 8'h40);
      rd(REG_FLAGS, 8'h04);
      wr(REG_ENABLE, 8'h84);
      rd(REG_FLAGS, 8'h84);
      pulse(7'h00, 7'h04);
      rd(REG_FLAGS, 8'h00);
      irq(8'h01);
      wr(REG_ENABLE, 8'h7f);
      pulse(7'h1b, 7'h00);
      // port accesses clear line 1 flags, and line 2 flags unless line 2 is independent
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {ca_ind, cb_ind} <= pind[i];
         host.acc(psel[i], i[0], 8'h00);
         rd(REG_FLAGS, pexp[i]);
      end
      pulse(7'h09, 7'h00);
      @(posedge clk);
      {ca_ind, cb_ind} <= 2'b11;
      wr(REG_FLAGS, 8'h09);
      rd(REG_FLAGS, 8'h00);
      rd(4'h5, 8'h00);
      summarize;
   end
endmodule
